// file: bss_sequencer.sv
// Buck switch sequencer: power switch timing, protections and register slave
`timescale 1ns/10ps
module bss_sequencer #(
   parameter int unsigned HICCUP_CYCLES = 8192
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_b_i,
   input  wire bss_pkg::bss_cmp_t      cmp_i,
   output logic                        hs_on_o,
   output logic                        ls_on_o,
   output logic                        ss_discharge_o,
   output logic                        ss_ref_sel_o,
   input  wire logic [bss_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                   s_axi_awvalid_i,
   output logic                        s_axi_awready_o,
   input  wire logic [31:0]            s_axi_wdata_i,
   input  wire logic [3:0]             s_axi_wstrb_i,
   input  wire logic                   s_axi_wvalid_i,
   output logic                        s_axi_wready_o,
   output logic [1:0]                  s_axi_bresp_o,
   output logic                        s_axi_bvalid_o,
   input  wire logic                   s_axi_bready_i,
   input  wire logic [bss_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                   s_axi_arvalid_i,
   output logic                        s_axi_arready_o,
   output logic [31:0]                 s_axi_rdata_o,
   output logic [1:0]                  s_axi_rresp_o,
   output logic                        s_axi_rvalid_o,
   input  wire logic                   s_axi_rready_i
);
   import bss_pkg::*;

   localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_CYCLES - 1);

   // Register address check, used by both read and write paths
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_COUNT);
   endfunction : addr_mapped

   // State code shown to software
   function automatic logic [2:0] state_code(input bss_state_t s);
      case (s)
         BSS_OFF:       state_code = 3'h0;
         BSS_SOFTSTART: state_code = 3'h1;
         BSS_RUN:       state_code = 3'h2;
         BSS_HICCUP:    state_code = 3'h3;
         BSS_THERMAL:   state_code = 3'h4;
         default:       state_code = 3'h7;
      endcase
   endfunction : state_code

   bss_state_t        state;
   bss_state_t        next_state;
   logic [2:0]        ctrl;
   bss_evt_t          evt;
   logic [OCP_W-1:0]  ocp_run;
   logic [HIC_W-1:0]  hic_cnt;
   logic              cycle_trip;
   logic              pfm_active;
   logic              next_hs;
   logic              next_ls;
   logic              cycle_start;
   logic              aw_got;
   logic              w_got;
   logic [ADDR_W-1:0] waddr;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;

   // Switching clock with spread spectrum
   bss_dither u_dither (
      .clk_i         (clk_i),
      .rst_b_i       (rst_b_i),
      .dither_en_i   (ctrl[CTRL_DITH_BIT]),
      .cycle_start_o (cycle_start)
   );

   // Operating conditions decoded from comparators and control
   wire active      = (state == BSS_SOFTSTART) || (state == BSS_RUN);
   wire go_off      = cmp_i.en_below_fall || cmp_i.uvlo || !ctrl[CTRL_RUN_BIT];
   wire may_start   = cmp_i.en_above_rise && !cmp_i.uvlo && ctrl[CTRL_RUN_BIT];
   wire pfm_mode    = ctrl[CTRL_PFM_BIT] && cmp_i.comp_clamped;
   wire hiccup_trip = cycle_start && cycle_trip && (ocp_run == OCP_RUN_LAST);
   wire hs_cutoff   = hs_on_o && (cmp_i.sum_above_comp || cmp_i.peak_limit);
   wire pfm_skip    = pfm_mode && cmp_i.sum_above_comp;
   wire do_write    = aw_got && w_got && !s_axi_bvalid_o;
   wire wr_ctrl     = do_write && (waddr == REG_CTRL) && wstrb[0];
   wire wr_status   = do_write && (waddr == REG_STATUS) && wstrb[1];
   wire [3:0] evt_clr = wr_status ? wdata[ST_EVT_LSB +: 4] : 4'h0;
   wire [3:0] evt_set = {cmp_i.uvlo && state != BSS_OFF,
                         cmp_i.tsd_hot && state != BSS_THERMAL,
                         hiccup_trip,
                         cmp_i.ovp && active};

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         BSS_OFF: begin
            if (may_start && !cmp_i.tsd_hot) begin
               next_state = BSS_SOFTSTART;
            end
         end
         BSS_SOFTSTART, BSS_RUN: begin
            if (state == BSS_SOFTSTART && cmp_i.ss_above_ref) begin
               next_state = BSS_RUN;
            end
            if (hiccup_trip) begin
               next_state = BSS_HICCUP;
            end
         end
         BSS_HICCUP: begin
            if (cycle_start && hic_cnt == HIC_LAST) begin
               next_state = BSS_SOFTSTART;
            end
         end
         BSS_THERMAL: begin
            if (cmp_i.tsd_cool && !cmp_i.tsd_hot) begin
               next_state = BSS_SOFTSTART;
            end
         end
         default: next_state = BSS_OFF;
      endcase
      if (cmp_i.tsd_hot && state != BSS_OFF) begin
         next_state = BSS_THERMAL;
      end
      if (go_off) begin
         next_state = BSS_OFF;
      end
   end

   // Power switch drive for the next cycle
   always_comb begin
      next_hs = hs_on_o;
      next_ls = ls_on_o;
      // ramp crossing hands over to low side
      // peak trip cuts high side at once
      if (hs_cutoff) begin
         next_hs = 1'b0;
         next_ls = 1'b1;
      end
      // zero cross ends low side in light load
      if (pfm_mode && ls_on_o && cmp_i.zero_cross) begin
         next_ls = 1'b0;
      end
      if (cycle_start) begin
         // cycle start turns high side on
         // low side off at next cycle
         // switching every cycle in heavy load
         // light load skips pulses at the clamp
         next_hs = !pfm_skip;
         next_ls = 1'b0;
      end
      if (cmp_i.ovp) begin
         next_hs = 1'b0;
         next_ls = 1'b1;
      end
      if (next_state != BSS_SOFTSTART && next_state != BSS_RUN) begin
         next_hs = 1'b0;
         next_ls = 1'b0;
      end
   end

   // State and switch registers
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state   <= BSS_OFF;
         hs_on_o <= 1'b0;
         ls_on_o <= 1'b0;
      end else begin
         state   <= next_state;
         hs_on_o <= next_hs;
         ls_on_o <= next_ls;
      end
   end

   // Soft-start pin control and reference selection
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ss_discharge_o <= 1'b1;
         ss_ref_sel_o   <= 1'b0;
         pfm_active     <= 1'b0;
      end else begin
         ss_discharge_o <= !(next_state == BSS_SOFTSTART || next_state == BSS_RUN);
         // lower of ramp and reference during soft-start
         ss_ref_sel_o   <= (next_state == BSS_SOFTSTART);
         pfm_active     <= pfm_mode && active;
      end
   end

   // Peak trip memory for the current switching cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cycle_trip <= 1'b0;
      end else if (cycle_start || !active) begin
         cycle_trip <= 1'b0;
      end else if (hs_on_o && cmp_i.peak_limit) begin
         cycle_trip <= 1'b1;
      end
   end

   // run counter clears on clean cycle or shutdown
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !active || go_off || cmp_i.tsd_hot) begin
         ocp_run <= '0;
      end else if (cycle_start) begin
         ocp_run <= cycle_trip ? OCP_W'(ocp_run + 1'b1) : '0;
      end
   end

   // hiccup down time counted in switching cycles
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || state != BSS_HICCUP) begin
         hic_cnt <= '0;
      end else if (cycle_start) begin
         hic_cnt <= HIC_W'(hic_cnt + 1'b1);
      end
   end

   // Control register and sticky events, a new event wins over its clear
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ctrl <= CTRL_RESET;
         evt  <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wdata[2:0];
         end
         evt <= (evt & ~evt_clr) | evt_set;
      end
   end

   // Write address and data capture, in either order
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         aw_got          <= 1'b0;
         w_got           <= 1'b0;
         waddr           <= '0;
         wdata           <= 32'h00000000;
         wstrb           <= 4'h0;
      end else begin
         s_axi_awready_o <= s_axi_awvalid_i && !s_axi_awready_o && !aw_got && !s_axi_bvalid_o;
         s_axi_wready_o  <= s_axi_wvalid_i && !s_axi_wready_o && !w_got && !s_axi_bvalid_o;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got <= 1'b1;
            waddr  <= s_axi_awaddr_i;
         end else if (do_write) begin
            aw_got <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got <= 1'b1;
            wdata <= s_axi_wdata_i;
            wstrb <= s_axi_wstrb_i;
         end else if (do_write) begin
            w_got <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= addr_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // Read data selection
   wire [31:0] st_word = {20'h00000, evt, 2'h0, pfm_active, ls_on_o, hs_on_o, state_code(state)};
   wire [31:0] cnt_word = {hic_cnt, 6'h00, ocp_run};
   wire [31:0] rd_word = (s_axi_araddr_i == REG_CTRL)   ? {29'h00000000, ctrl} :
                         (s_axi_araddr_i == REG_STATUS) ? st_word :
                         (s_axi_araddr_i == REG_COUNT)  ? cnt_word : 32'h00000000;

   // Read channel
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= RESP_OKAY;
      end else begin
         s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule : bss_sequencer

// file: bss_pkg.sv
// Package of constants and carrier types for the buck switch sequencer
package bss_pkg;
   // Clock and switching period
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned FSW_KHZ        = 570;
   localparam int unsigned SW_PERIOD_NS   = 1000000 / FSW_KHZ;
   localparam int unsigned PCNT_W         = 7;
   localparam logic [6:0]  SW_PERIOD_CYC  = 7'(SW_PERIOD_NS / CLK_PERIOD_NS);
   // Spread spectrum deviation, percent of nominal period
   localparam int unsigned DITHER_PCT     = 6;
   localparam logic [6:0]  DITHER_DEV_CYC = 7'((SW_PERIOD_NS / CLK_PERIOD_NS) * DITHER_PCT / 100);
   // Protection counts in switching cycles
   localparam int unsigned OCP_RUN_CYCLES = 512;
   localparam int unsigned OCP_W          = 10;
   localparam logic [9:0]  OCP_RUN_LAST   = 10'(OCP_RUN_CYCLES - 1);
   localparam int unsigned HIC_W          = 16;
   // Register offsets
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_COUNT      = 8'h08;
   // Control field positions and reset values
   localparam int unsigned CTRL_RUN_BIT   = 0;
   localparam int unsigned CTRL_DITH_BIT  = 1;
   localparam int unsigned CTRL_PFM_BIT   = 2;
   localparam logic [2:0]  CTRL_RESET     = 3'h7;
   // Status field positions
   localparam int unsigned ST_STATE_LSB   = 0;
   localparam int unsigned ST_HS_BIT      = 3;
   localparam int unsigned ST_LS_BIT      = 4;
   localparam int unsigned ST_PFM_BIT     = 5;
   localparam int unsigned ST_EVT_LSB     = 8;
   localparam int unsigned CNT_HIC_LSB    = 16;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Sequencer states
   typedef enum logic [2:0] {
      BSS_OFF,
      BSS_SOFTSTART,
      BSS_RUN,
      BSS_HICCUP,
      BSS_THERMAL
   } bss_state_t;

   // Comparator results from the analog loop
   typedef struct packed {
      logic en_above_rise;   // Enable above rising threshold
      logic en_below_fall;   // Enable below falling threshold
      logic uvlo;            // Supply below lockout level
      logic ovp;             // Output above target by margin
      logic sum_above_comp;  // Summed ramp signal above compensation level
      logic peak_limit;      // Peak current limit tripped
      logic zero_cross;      // Inductor current reached zero
      logic comp_clamped;    // Compensation held at light-load clamp
      logic tsd_hot;         // Junction at shutdown limit
      logic tsd_cool;        // Junction back at recovery level
      logic ss_above_ref;    // Soft-start ramp above internal reference
   } bss_cmp_t;

   // Sticky event flags
   typedef struct packed {
      logic uvlo;
      logic thermal;
      logic hiccup;
      logic ovp;
   } bss_evt_t;
endpackage : bss_pkg

// file: bss_dither.sv
// Switching clock divider with triangular spread-spectrum period
`timescale 1ns/10ps
module bss_dither (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic dither_en_i,
   output logic      cycle_start_o
);
   import bss_pkg::*;

   logic [6:0] period_cnt;
   logic [6:0] offs;
   logic       up;
   wire  [6:0] period_len;
   wire        period_end;
   wire  [6:0] offs_top;

   // Period swings from nominal minus deviation to nominal plus deviation
   assign offs_top   = 7'(DITHER_DEV_CYC << 1);
   assign period_len = dither_en_i ? 7'(SW_PERIOD_CYC - DITHER_DEV_CYC + offs) : SW_PERIOD_CYC;
   assign period_end = (period_cnt >= 7'(period_len - 7'h01));

   // Period counter and cycle start pulse
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         period_cnt    <= 7'h00;
         cycle_start_o <= 1'b0;
      end else begin
         period_cnt    <= period_end ? 7'h00 : 7'(period_cnt + 7'h01);
         cycle_start_o <= period_end;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         offs <= DITHER_DEV_CYC;
         up   <= 1'b1;
      end else if (period_end) begin
         if (up) begin
            offs <= 7'(offs + 7'h01);
            up   <= (7'(offs + 7'h01) < offs_top);
         end else begin
            offs <= 7'(offs - 7'h01);
            up   <= (offs == 7'h01);
         end
      end
   end
endmodule : bss_dither

// file: bss_analog_model.sv
// Behavioural model of the analog comparators around the sequencer
`timescale 1ns/10ps
module bss_analog_model (
   input  wire logic              clk_i,
   input  wire bss_pkg::bss_cmp_t env_i,
   input  wire logic              hs_on_i,
   input  wire logic              ls_on_i,
   input  wire logic              ss_ref_sel_i,
   input  wire logic              overload_i,
   output bss_pkg::bss_cmp_t      cmp_o
);
   import bss_pkg::*;
   logic [6:0] t_hs;
   logic [6:0] t_ls;
   logic [6:0] t_ss;
   // Time spent in each conduction phase and in soft-start
   always_ff @(posedge clk_i) begin
      t_hs <= hs_on_i ? t_hs + 7'h01 : 7'h00;
      t_ls <= ls_on_i ? t_ls + 7'h01 : 7'h00;
      t_ss <= ss_ref_sel_i ? t_ss + 7'h01 : 7'h00;
   end
   // Ramp meets compensation after 20 cycles; an overload trips the limit after 5
   // clamp gives a short light-load pulse that ends in a zero cross
   always_comb begin
      cmp_o = env_i;
      cmp_o.sum_above_comp = hs_on_i && (t_hs >= 7'h14);
      cmp_o.peak_limit = hs_on_i && overload_i && (t_hs >= 7'h05);
      cmp_o.zero_cross = ls_on_i && env_i.comp_clamped && (t_ls >= 7'h0A);
      cmp_o.ss_above_ref = ss_ref_sel_i && (t_ss >= 7'h1E);
   end
endmodule : bss_analog_model

// file: bss_seq_properties.sv
// Concurrent checks on the switch and soft-start outputs of the sequencer
`timescale 1ns/10ps
module bss_seq_properties #(
   parameter int unsigned HICCUP_CYCLES = 8192
) (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire bss_pkg::bss_cmp_t cmp_i,
   input  wire logic              hs_on_o,
   input  wire logic              ls_on_o,
   input  wire logic              ss_discharge_o,
   input  wire logic              ss_ref_sel_o
);
   import bss_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   localparam int MIN_GAP = int'(SW_PERIOD_CYC) - int'(DITHER_DEV_CYC);
   logic       hs_q;
   logic       gap_ok;
   logic [7:0] gap;
   // Turn-on edge and shutdown requests
   wire hs_rise  = hs_on_o && !hs_q;
   wire stop_req = cmp_i.uvlo || cmp_i.en_below_fall || cmp_i.tsd_hot;
   // Cycles since the last high-side turn-on, void across a shutdown
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hs_q <= 1'b0;
         gap <= 8'h00;
         gap_ok <= 1'b0;
      end else begin
         hs_q <= hs_on_o;
         if (hs_rise) begin
            gap <= 8'h01;
            gap_ok <= !ss_discharge_o;
         end else begin
            gap <= (gap == 8'hFF) ? gap : gap + 8'h01;
            gap_ok <= gap_ok && !ss_discharge_o;
         end
      end
   end
   sequence in_softstart;
      ss_ref_sel_o && !ss_discharge_o;
   endsequence
   sequence ramp_done;
      cmp_i.ss_above_ref && !stop_req;
   endsequence
   no_overlap_a: assert property (!(hs_on_o && ls_on_o))
      else $error("both switches on");
   ramp_end_a: assert property (hs_on_o && cmp_i.sum_above_comp && !stop_req
         |=> !hs_on_o && ls_on_o)
      else $error("ramp crossing did not hand over");
   peak_trip_a: assert property (hs_on_o && cmp_i.peak_limit |=> !hs_on_o)
      else $error("peak trip left high side on");
   ovp_hs_off_a: assert property (cmp_i.ovp |=> !hs_on_o)
      else $error("overvoltage left high side on");
   ovp_ls_on_a: assert property (cmp_i.ovp && !ss_discharge_o && !stop_req |=> ls_on_o)
      else $error("overvoltage did not turn low side on");
   uvlo_off_a: assert property (cmp_i.uvlo |=> !hs_on_o && !ls_on_o)
      else $error("lockout left a switch on");
   thermal_off_a: assert property (cmp_i.tsd_hot |=> !hs_on_o && !ls_on_o && ss_discharge_o)
      else $error("thermal limit left converter on");
   enable_off_a: assert property (cmp_i.en_below_fall
         |=> ss_discharge_o && !hs_on_o && !ls_on_o)
      else $error("disable did not discharge soft-start");
   start_gap_a: assert property (hs_rise && gap_ok |-> gap >= MIN_GAP)
      else $error("switching period too short");
   ss_finish_a: assert property ((in_softstart ##0 ramp_done)
         |=> !ss_ref_sel_o && !ss_discharge_o)
      else $error("soft-start did not end");
endmodule : bss_seq_properties
bind bss_sequencer bss_seq_properties #(.HICCUP_CYCLES(HICCUP_CYCLES)) prop_u (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .cmp_i(cmp_i), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o),
   .ss_discharge_o(ss_discharge_o), .ss_ref_sel_o(ss_ref_sel_o));

// file: testbench.sv
// Self-checking bench for the buck switch sequencer
`timescale 1ns/10ps
module testbench;
   import bss_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] e;
      logic [1:0]  r;
   } bss_row_t;
   logic clk_i = 1'b0, rst_b_i = 1'b0, overload = 1'b0;
   bss_cmp_t env = '0, cmp;
   logic hs, ls, ssd, ssr, hs_d, bad;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   int n_fail = 0, n_compared = 0, n, k, lo, hi;
   bss_row_t rows [4] = '{'{REG_CTRL, 32'(CTRL_RESET), RESP_OKAY}, '{REG_STATUS, 32'h0, RESP_OKAY},
                         '{REG_COUNT, 32'h0, RESP_OKAY}, '{8'h0C, 32'h0, RESP_SLVERR}};
   bss_sequencer #(.HICCUP_CYCLES(4)) dut_u (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .cmp_i(cmp), .hs_on_o(hs), .ls_on_o(ls),
      .ss_discharge_o(ssd), .ss_ref_sel_o(ssr), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready));
   bss_analog_model model_u (.clk_i(clk_i), .env_i(env), .hs_on_i(hs), .ls_on_i(ls),
      .ss_ref_sel_i(ssr), .overload_i(overload), .cmp_o(cmp));
   // Clock and delayed copy of the high-side switch
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) hs_d <= hs;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // Write with address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
      logic aw_t, w_t;
      @(posedge clk_i);
      {awaddr, wdata, wstrb} <= {a, wd, s};
      {awvalid, wvalid, bready} <= 3'b111;
      aw_t = 1'b0;
      w_t = 1'b0;
      while (!(aw_t && w_t)) begin
         @(posedge clk_i);
         if (awvalid && awready === 1'b1) begin aw_t = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready === 1'b1) begin w_t = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge clk_i); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e,
                       input logic [1:0] er);
      @(posedge clk_i);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      chk(nm, e, d & m);
      chk("rresp", 32'(er), 32'(rresp));
   endtask : rchk
   // Edges until the next high-side turn-on
   task automatic next_rise(output int c);
      c = 0;
      do begin @(posedge clk_i); c++; end while (!(hs === 1'b1 && hs_d === 1'b0) && c < 400);
   endtask : next_rise
   task automatic wait_ssr(output int c);
      c = 0;
      while (ssr !== 1'b1 && c < 1000) begin
         @(posedge clk_i);
         c++;
         if (ssd !== 1'b1 && !ssr) bad = 1'b1;
      end
   endtask : wait_ssr
   initial begin
      repeat (90000) @(posedge clk_i);
      n_fail++;
      report_and_stop();
   end
   initial begin
      bad = 1'b0;
      repeat (10) @(posedge clk_i);
      chk("reset switches", 32'h0, {hs, ls, ssr});
      chk("reset discharge", 32'h1, ssd);
      rst_b_i <= 1'b1;
      foreach (rows[i]) rchk("reset register", rows[i].a, 32'hFFFFFFFF, rows[i].e, rows[i].r);
      env.en_above_rise <= 1'b1;
      wait_ssr(k);
      chk("soft-start", 32'h0, ssd);
      repeat (40) @(posedge clk_i);
      rchk("state run", REG_STATUS, 32'h7, 32'(BSS_RUN), RESP_OKAY);
      next_rise(n);
      lo = 255;
      hi = 0;
      repeat (30) begin next_rise(n); lo = (n < lo) ? n : lo; hi = (n > hi) ? n : hi; end
      chk("short period", 32'(SW_PERIOD_CYC - DITHER_DEV_CYC), lo);
      chk("long period", 32'(SW_PERIOD_CYC + DITHER_DEV_CYC), hi);
      repeat (25) @(posedge clk_i);
      chk("low side after ramp", 32'h1, {hs, ls});
      axi_write(REG_CTRL, 32'h5, 4'h1);
      repeat (2) next_rise(n);
      repeat (4) begin next_rise(n); chk("fixed period", 32'(SW_PERIOD_CYC), n); end
      env.ovp <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("ovp switches", 32'h1, {hs, ls});
      env.ovp <= 1'b0;
      // light load cut at zero cross, ignored in forced width mode
      env.comp_clamped <= 1'b1;
      repeat (2) next_rise(n);
      repeat (45) @(posedge clk_i);
      chk("zero cross cut", 32'h0, {hs, ls});
      rchk("light mode", REG_STATUS, 32'h20, 32'h20, RESP_OKAY);
      axi_write(REG_CTRL, 32'h1, 4'h1);
      repeat (2) next_rise(n);
      repeat (45) @(posedge clk_i);
      chk("forced width", 32'h1, {hs, ls});
      axi_write(REG_CTRL, 32'h5, 4'h1);
      env.comp_clamped <= 1'b0;
      // trips counted, then cleared by a clean cycle
      overload <= 1'b1;
      // A tripped cycle is counted only when the next cycle starts
      repeat (4) next_rise(n);
      rchk("trip count", REG_COUNT, 32'h3FF, 32'h3, RESP_OKAY);
      overload <= 1'b0;
      repeat (2) next_rise(n);
      rchk("count cleared", REG_COUNT, 32'h3FF, 32'h0, RESP_OKAY);
      // hiccup after the trip run, restart through soft-start
      next_rise(n);
      repeat (25) @(posedge clk_i);
      overload <= 1'b1;
      k = 0;
      n = 0;
      while (ssd !== 1'b1 && k < 50000) begin
         @(posedge clk_i);
         k++;
         if (hs === 1'b1 && hs_d === 1'b0) n++;
      end
      chk("tripped cycles", 32'(OCP_RUN_CYCLES), n);
      rchk("state hiccup", REG_STATUS, 32'h7, 32'(BSS_HICCUP), RESP_OKAY);
      overload <= 1'b0;
      wait_ssr(k);
      chk("down time", 32'h1, (k >= 4 * SW_PERIOD_CYC - 8) && (k <= 4 * SW_PERIOD_CYC + 4));
      chk("held discharged", 32'h0, bad);
      repeat (40) @(posedge clk_i);
      env.tsd_hot <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("thermal off", 32'h1, {hs, ls, ssd});
      rchk("state thermal", REG_STATUS, 32'h7, 32'(BSS_THERMAL), RESP_OKAY);
      env.tsd_hot <= 1'b0;
      env.tsd_cool <= 1'b1;
      wait_ssr(k);
      chk("thermal restart", 32'h1, ssr);
      env.tsd_cool <= 1'b0;
      // lockout, sticky events and unmapped write
      env.uvlo <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("lockout off", 32'h0, {hs, ls});
      rchk("events", REG_STATUS, 32'hF07, 32'hF00, RESP_OKAY);
      axi_write(REG_STATUS, 32'h0F00, 4'h2);
      // Lockout flag is raised only when it stops the sequencer from a state other than off
      rchk("events cleared", REG_STATUS, 32'hF00, 32'h000, RESP_OKAY);
      axi_write(8'h10, 32'h1, 4'hF);
      chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
      env.uvlo <= 1'b0;
      wait_ssr(k);
      env.en_above_rise <= 1'b0;
      env.en_below_fall <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("disabled", 32'h1, {hs, ls, ssd});
      rchk("state off", REG_STATUS, 32'h7, 32'(BSS_OFF), RESP_OKAY);
      report_and_stop();
   end
endmodule : testbench
